// file: design/hub_strap_and_pullup_control.sv
// Strap decoding, shared pin steering, port power and pullup control
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "hub_strap_map.svh"

module hub_strap_and_pullup_control #(
  parameter logic [`DELAY_COUNT_WIDTH-1:0] PULLUP_DELAY_CYCLES =
    `DELAY_COUNT_WIDTH'(`PULLUP_DELAY_CYCLES)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire hub_strap_pkg::word_type pwdata,
  output hub_strap_pkg::word_type prdata,
  output logic pready,
  output logic pslverr,
  // Board straps
  input wire logic power_source_strap,
  input wire logic eeprom_enable_strap,
  // USB bus reset seen by the upstream port
  input wire logic usb_bus_reset,
  // Upstream pullup control pin
  output logic upstream_pullup_ctrl_out,
  output logic upstream_pullup_ctrl_oe,
  // EEPROM serial clock pin
  output logic eeprom_serial_clock_out,
  output logic eeprom_serial_clock_oe,
  output logic eeprom_serial_clock_pd_en,
  // Shared EEPROM data and ganged select pin
  input wire logic eeprom_serial_line_in,
  output logic eeprom_serial_line_out,
  output logic eeprom_serial_line_oe,
  output logic eeprom_serial_line_pd_en,
  // Downstream port power
  input wire hub_strap_pkg::port_vec_type overcurrent_n,
  output hub_strap_pkg::port_vec_type port_power_on_n,
  // Decoded configuration
  output logic self_powered,
  output logic ganged_mode,
  output logic [15:0] vendor_id,
  output logic [15:0] product_id
);
  import hub_strap_pkg::*;

  // Synchroniser stages for every pin input
  logic pwr_strap_s1_reg;
  logic pwr_strap_s2_reg;
  logic ee_strap_s1_reg;
  logic ee_strap_s2_reg;
  logic line_s1_reg;
  logic line_s2_reg;
  logic bus_reset_s1_reg;
  logic bus_reset_s2_reg;
  port_vec_type oc_s1_reg;
  port_vec_type oc_s2_reg;

  // Edge history and register file
  logic pwr_strap_prev_reg;
  logic [2:0] primed_reg;
  word_type ctrl_reg;
  word_type id_load_reg;
  port_vec_type oc_latch_reg;
  port_vec_type oc_latch_next;
  port_vec_type power_on_reg;
  logic pullup_on_reg;
  logic ganged_reg;
  word_type prdata_reg;

  // Decoded strap and bus signals
  wire logic eeprom_enabled;
  wire logic strap_changed;
  wire logic delay_restart;
  wire logic delay_expired;
  wire logic wr_en;
  wire logic rd_en;
  wire logic addr_mapped;
  wire port_vec_type power_req;
  wire port_vec_type power_cut;
  wire port_vec_type power_on_next;
  wire port_vec_type oc_clear;
  wire port_vec_type oc_event;
  wire word_type status_word;
  wire word_type id_word;
  wire word_type read_word;

  // True when the APB address equals this register's offset, in either phase
  function automatic logic reg_hit(input logic [11:0] addr,
                                   input logic [11:0] target);
    reg_hit = (addr == target);
  endfunction

  // Two-flop synchronisers; first stages feed only the second
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_strap_s1_reg <= 1'h0;
      pwr_strap_s2_reg <= 1'h0;
      ee_strap_s1_reg <= 1'h1;
      ee_strap_s2_reg <= 1'h1;
      line_s1_reg <= 1'h0;
      line_s2_reg <= 1'h0;
      bus_reset_s1_reg <= 1'h0;
      bus_reset_s2_reg <= 1'h0;
      oc_s1_reg <= 3'h7;
      oc_s2_reg <= 3'h7;
    end else begin
      pwr_strap_s1_reg <= power_source_strap;
      pwr_strap_s2_reg <= pwr_strap_s1_reg;
      ee_strap_s1_reg <= eeprom_enable_strap;
      ee_strap_s2_reg <= ee_strap_s1_reg;
      line_s1_reg <= eeprom_serial_line_in;
      line_s2_reg <= line_s1_reg;
      bus_reset_s1_reg <= usb_bus_reset;
      bus_reset_s2_reg <= bus_reset_s1_reg;
      oc_s1_reg <= overcurrent_n;
      oc_s2_reg <= oc_s1_reg;
    end
  end

  // Strap history; compares start only once the sync stages and the
  // history hold real pin samples, so a high strap at reset is no edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_strap_prev_reg <= 1'h0;
      primed_reg <= 3'h0;
    end else begin
      pwr_strap_prev_reg <= pwr_strap_s2_reg;
      primed_reg <= {primed_reg[1:0], 1'h1};
    end
  end

  // A power-source strap change either way restarts the delay; the enable strap and bus reset play no part
  assign strap_changed = primed_reg[2] &
    (pwr_strap_s2_reg != pwr_strap_prev_reg); // RULE4
  assign delay_restart = strap_changed; // RULE5

  // Delay timer; system reset restarts it through reset_n alone
  pullup_delay_timer #(
    .DELAY_CYCLES(PULLUP_DELAY_CYCLES)
  ) u_delay (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .restart(delay_restart),
    .expired(delay_expired)
  );

  // Pullup pin floats until expiry, then drives high
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pullup_on_reg <= 1'h0; // RULE3
    end else begin
      pullup_on_reg <= delay_expired & ~delay_restart; // RULE6
    end
  end
  assign upstream_pullup_ctrl_out = pullup_on_reg; // RULE6
  assign upstream_pullup_ctrl_oe = pullup_on_reg; // RULE3

  // Strap decode: low enable strap means the EEPROM port is live
  assign eeprom_enabled = ~ee_strap_s2_reg; // RULE7
  assign self_powered = pwr_strap_s2_reg; // RULE1

  // Ganged select is only meaningful with the EEPROM disabled
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ganged_reg <= 1'h0;
    end else begin
      ganged_reg <= ~eeprom_enabled & line_s2_reg; // RULE9
    end
  end
  assign ganged_mode = ganged_reg;

  // Clock pin: software bit-bang when enabled, otherwise left undriven
  assign eeprom_serial_clock_out = eeprom_enabled & ctrl_reg[`CTRL_SCLK];
  assign eeprom_serial_clock_oe =
    eeprom_enabled & ctrl_reg[`CTRL_SCLK_OE]; // RULE8
  assign eeprom_serial_clock_pd_en = eeprom_enabled; // RULE7

  // Data pin: bidirectional line only when enabled, else pure input
  assign eeprom_serial_line_out = eeprom_enabled & ctrl_reg[`CTRL_SDATA];
  assign eeprom_serial_line_oe =
    eeprom_enabled & ctrl_reg[`CTRL_SDATA_OE]; // RULE10
  assign eeprom_serial_line_pd_en = eeprom_enabled; // RULE10

  // APB decode; zero wait states, error on unmapped addresses
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_mapped = reg_hit(paddr, `ADDR_CTRL) |
    reg_hit(paddr, `ADDR_STATUS) | reg_hit(paddr, `ADDR_OC_CLEAR) |
    reg_hit(paddr, `ADDR_ID) | reg_hit(paddr, `ADDR_ID_LOAD);
  assign pready = 1'h1;
  assign pslverr = psel & penable & ~addr_mapped;

  // Writable registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `CTRL_RESET;
      id_load_reg <= '0;
    end else begin
      if (wr_en && reg_hit(paddr, `ADDR_CTRL)) begin
        ctrl_reg <= pwdata;
      end
      if (wr_en && reg_hit(paddr, `ADDR_ID_LOAD)) begin
        id_load_reg <= pwdata;
      end
    end
  end

  // Overcurrent latches: a fresh event beats a software or bus clear
  assign oc_event = ~oc_s2_reg;
  assign oc_clear = (wr_en && reg_hit(paddr, `ADDR_OC_CLEAR)) ?
    pwdata[2:0] : 3'h0;
  always_comb begin
    oc_latch_next = oc_latch_reg & ~oc_clear;
    if (bus_reset_s2_reg) begin
      oc_latch_next = 3'h0;
    end
    oc_latch_next = oc_latch_next | oc_event;
  end

  // Ganged cuts every port; per-port cuts the affected one
  assign power_req = ctrl_reg[`CTRL_PWR_HI:`CTRL_PWR_LO];
  assign power_cut = ganged_reg ? {3{|oc_latch_reg}} : oc_latch_reg; // RULE14
  assign power_on_next = power_req & ~power_cut; // RULE14

  // Port power outputs are registered, active low on the pins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      oc_latch_reg <= 3'h0;
      power_on_reg <= 3'h0;
    end else begin
      oc_latch_reg <= oc_latch_next;
      power_on_reg <= power_on_next;
    end
  end
  assign port_power_on_n = ~power_on_reg;

  // Default IDs unless the EEPROM is live and software loaded its IDs
  assign id_word = (eeprom_enabled & ctrl_reg[`CTRL_ID_LOADED]) ?
    id_load_reg :
    {`DEFAULT_PRODUCT_ID, `DEFAULT_VENDOR_ID}; // RULE13
  assign vendor_id = id_word[15:0];
  assign product_id = id_word[31:16];

  // Status view; the pair field shows the fixed upstream root pair
  assign status_word = {
    14'h0,
    `UPSTREAM_PAIR, // RULE12
    1'h0, power_on_reg,
    1'h0, oc_latch_reg,
    3'h0,
    line_s2_reg,
    pullup_on_reg,
    ganged_reg,
    eeprom_enabled,
    self_powered
  };

  // Read selection; unmapped and write-only locations read as zero
  assign read_word =
    reg_hit(paddr, `ADDR_CTRL) ? ctrl_reg :
    reg_hit(paddr, `ADDR_STATUS) ? status_word :
    reg_hit(paddr, `ADDR_ID) ? id_word :
    reg_hit(paddr, `ADDR_ID_LOAD) ? id_load_reg : '0;

  // Read data come from a register loaded in the setup phase
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= read_word;
    end
  end
  assign prdata = (rd_en) ? prdata_reg : '0;

endmodule
`default_nettype wire

// file: design/hub_strap_map.svh
// Offsets, field positions, reset values and timing of the strap block
// Notes on behaviour
// RULE1: Power-source strap low means bus-powered, high means self-powered.
// RULE2: Board holds the power-source strap steady while the hub runs.
// RULE3: After system reset the pullup output floats until 15 ms elapse.
// RULE4: Any power-source strap change floats the pullup and restarts the delay.
// RULE5: Only system reset or a power-source strap change restarts the delay; USB bus reset does not.
// RULE6: After expiry the pullup output is driven high until the next trigger.
// RULE7: EEPROM-enable strap high disables the interface; clock pin stays unused.
// RULE8: EEPROM-enable strap low makes the clock pin three-state, weak pulldown.
// RULE9: EEPROM-enable strap high reads the shared pin as ganged select.
// RULE10: EEPROM-enable strap low makes the shared pin bidirectional data, pulldown.
// RULE11: Board keeps the ganged select level static while it serves so.
// RULE12: Pair zero is the upstream root port, pairs one to three downstream.
// RULE13: With EEPROM disabled, built-in default vendor and product IDs report.
// RULE14: Per-port overcurrent cuts its port only; ganged cuts all ports.
// RULE15: Delay counter runs on the core clock and restarts from zero.
`ifndef HUB_STRAP_MAP_SVH
`define HUB_STRAP_MAP_SVH

// Register byte addresses
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_OC_CLEAR 12'h008
`define ADDR_ID 12'h00C
`define ADDR_ID_LOAD 12'h010

// Control register fields
`define CTRL_SCLK 0
`define CTRL_SDATA 1
`define CTRL_SDATA_OE 2
`define CTRL_SCLK_OE 3
`define CTRL_ID_LOADED 4
`define CTRL_PWR_LO 8
`define CTRL_PWR_HI 10
`define CTRL_RESET 32'h0000_0000

// Status register fields
`define STAT_SELF_POWERED 0
`define STAT_EEPROM_EN 1
`define STAT_GANGED 2
`define STAT_PULLUP_ON 3
`define STAT_SDATA_IN 4
`define STAT_OC_LO 8
`define STAT_OC_HI 10
`define STAT_PWR_LO 12
`define STAT_PWR_HI 14
`define STAT_UP_PAIR_LO 16
`define STAT_UP_PAIR_HI 17

// Pair numbering of the transceivers
`define UPSTREAM_PAIR 2'h0

// Built-in identifiers, arbitrary values
`define DEFAULT_VENDOR_ID 16'h1234
`define DEFAULT_PRODUCT_ID 16'h5678

// Pullup delay: time in microseconds and core clock rate in kHz
`define PULLUP_DELAY_US 15000
`define CORE_CLOCK_KHZ 125000
`define PULLUP_DELAY_CYCLES ((`PULLUP_DELAY_US * `CORE_CLOCK_KHZ) / 1000)
`define DELAY_COUNT_WIDTH 21

`endif

// file: design/hub_strap_pkg.sv
// Types shared by the strap and pullup control block
package hub_strap_pkg;

  // Pullup output phases
  typedef enum logic [1:0] {
    PULLUP_FLOAT = 2'b00,
    PULLUP_DRIVE = 2'b01
  } pullup_state_type;

  // Downstream port vector, pairs one to three
  typedef logic [2:0] port_vec_type;

  // APB data word
  typedef logic [31:0] word_type;

endpackage

// file: design/pullup_delay_timer.sv
// Delay counter that gates the upstream pullup after each trigger
`timescale 1ns/1ns
`default_nettype none
`include "hub_strap_map.svh"

module pullup_delay_timer #(
  parameter logic [`DELAY_COUNT_WIDTH-1:0] DELAY_CYCLES =
    `DELAY_COUNT_WIDTH'(`PULLUP_DELAY_CYCLES)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Trigger and result
  input wire logic restart,
  output logic expired
);
  import hub_strap_pkg::*;

  logic [`DELAY_COUNT_WIDTH-1:0] count_reg;
  logic [`DELAY_COUNT_WIDTH-1:0] count_next;
  pullup_state_type state_reg;
  pullup_state_type state_next;
  wire logic count_done;

  // Last cycle of the delay is DELAY_CYCLES-1 counted from zero
  assign count_done = (count_reg == DELAY_CYCLES - `DELAY_COUNT_WIDTH'(1));

  // Counting and phase selection; restart always wins
  always_comb begin
    count_next = count_reg;
    state_next = state_reg;
    case (state_reg)
      PULLUP_FLOAT: begin
        if (count_done) begin
          state_next = PULLUP_DRIVE; // RULE6
        end else begin
          count_next = count_reg + `DELAY_COUNT_WIDTH'(1); // RULE15
        end
      end
      PULLUP_DRIVE: begin
        state_next = PULLUP_DRIVE;
      end
      default: begin
        state_next = PULLUP_FLOAT;
      end
    endcase
    if (restart) begin
      count_next = '0; // RULE15
      state_next = PULLUP_FLOAT; // RULE4
    end
  end

  // Reset floats the output and clears the count
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0; // RULE3
      state_reg <= PULLUP_FLOAT; // RULE3
    end else begin
      count_reg <= count_next;
      state_reg <= state_next;
    end
  end

  assign expired = (state_reg == PULLUP_DRIVE);

endmodule
`default_nettype wire

// file: dv/hub_board_model.sv
// Board straps and shared EEPROM data line around the strap block
`timescale 1ns/1ns
`default_nettype none

module hub_board_model (
  // Board settings chosen by the bench
  input wire logic self_power_sel,
  input wire logic eeprom_off_sel,
  input wire logic gang_sel,
  input wire logic [2:0] fault_n,
  // Device side of the shared data pin
  input wire logic line_out,
  input wire logic line_oe,
  input wire logic line_pd_en,
  // Pins into the device
  output logic power_source_strap,
  output logic eeprom_enable_strap,
  output logic eeprom_serial_line_in,
  output logic [2:0] overcurrent_n
);
  logic last_level = 1'h0;

  // Straps follow the bench settings directly; the bench moves them inside its tests
  assign power_source_strap = self_power_sel;
  assign eeprom_enable_strap = eeprom_off_sel;
  assign overcurrent_n = fault_n;

  // Device drive wins, then the ganged strap, then the pulldown; with
  // nothing holding it the line shows the opposite of its last level
  assign eeprom_serial_line_in = line_oe ? line_out :
    eeprom_off_sel ? gang_sel :
    line_pd_en ? 1'b0 : ~last_level;

  // Last level the device drove
  always @(line_out) begin
    last_level = line_out;
  end
endmodule
`default_nettype wire

// file: dv/hub_strap_properties.sv
// Port-level assertions for the strap and pullup control block
`timescale 1ns/1ns
`default_nettype none
`include "hub_strap_map.svh"

module hub_strap_properties #(
  parameter logic [`DELAY_COUNT_WIDTH-1:0] PULLUP_DELAY_CYCLES = 21'h00014
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Straps and pins in
  input wire logic power_source_strap,
  input wire logic eeprom_enable_strap,
  input wire logic eeprom_serial_line_in,
  input wire hub_strap_pkg::port_vec_type overcurrent_n,
  // Outputs watched
  input wire logic upstream_pullup_ctrl_out,
  input wire logic upstream_pullup_ctrl_oe,
  input wire logic eeprom_serial_clock_oe,
  input wire logic eeprom_serial_clock_pd_en,
  input wire logic eeprom_serial_line_pd_en,
  input wire hub_strap_pkg::port_vec_type port_power_on_n,
  input wire logic self_powered,
  input wire logic ganged_mode,
  input wire logic [15:0] vendor_id,
  input wire logic [15:0] product_id
);
  import hub_strap_pkg::*;
  int low_cnt;
  logic strap_q;
  logic [1:0] age;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Float time of the pullup; a strap edge starts three below zero to
  // cover the sync stages and the edge detector, so both triggers give
  // the same figure; the first sample after reset only primes strap_q
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= -1;
      strap_q <= 1'h0;
      age <= 2'h0;
    end else begin
      strap_q <= power_source_strap;
      age <= age + {1'b0, age != 2'h3};
      if (age != 2'h0 && strap_q != power_source_strap) begin
        low_cnt <= -3;
      end else if (upstream_pullup_ctrl_oe && low_cnt >= 0) begin
        low_cnt <= 0;
      end else begin
        low_cnt <= low_cnt + 1;
      end
    end
  end

  // Overcurrent held long enough to pass the sync stages and the latch
  sequence s_gang_fault;
    (ganged_mode && overcurrent_n != 3'h7) [*4];
  endsequence
  sequence s_port1_fault;
    (!ganged_mode && !overcurrent_n[1]) [*4];
  endsequence

  a_pullup_delay: assert property (
    $rose(upstream_pullup_ctrl_oe) |-> low_cnt == int'(PULLUP_DELAY_CYCLES))
    else $error("pullup driven after wrong delay");
  a_pullup_on_time: assert property (
    low_cnt == int'(PULLUP_DELAY_CYCLES) |->
    upstream_pullup_ctrl_oe && upstream_pullup_ctrl_out)
    else $error("pullup not driven at expiry");
  a_pullup_holds: assert property (
    ($stable(power_source_strap) [*3] ##0 upstream_pullup_ctrl_oe) |=>
    upstream_pullup_ctrl_oe)
    else $error("pullup released without trigger");
  a_power_source: assert property (
    ($stable(power_source_strap) [*2] ##0 age == 2'h3) |->
    self_powered == power_source_strap)
    else $error("power source decode wrong");
  a_clock_unused: assert property (
    eeprom_enable_strap [*4] |->
    !eeprom_serial_clock_oe && !eeprom_serial_clock_pd_en)
    else $error("clock pin active while disabled");
  a_pulldowns_on: assert property (
    ((!eeprom_enable_strap) [*4] ##0 age == 2'h3) |->
    eeprom_serial_clock_pd_en && eeprom_serial_line_pd_en)
    else $error("pulldown missing while enabled");
  a_ganged_select: assert property (
    ($stable({eeprom_enable_strap, eeprom_serial_line_in}) [*4] ##0
    age == 2'h3) |->
    ganged_mode == (eeprom_enable_strap && eeprom_serial_line_in))
    else $error("ganged select wrong");
  a_default_ids: assert property (
    eeprom_enable_strap [*4] |-> vendor_id == `DEFAULT_VENDOR_ID &&
    product_id == `DEFAULT_PRODUCT_ID)
    else $error("identifiers not default");
  a_gang_trip: assert property (
    s_gang_fault |=> port_power_on_n == 3'h7)
    else $error("ganged fault left a port on");
  a_port_trip: assert property (
    s_port1_fault |=> port_power_on_n[1])
    else $error("port fault left port on");
endmodule

bind hub_strap_and_pullup_control hub_strap_properties #(
  .PULLUP_DELAY_CYCLES(PULLUP_DELAY_CYCLES)
) u_hub_strap_properties (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .power_source_strap(power_source_strap),
  .eeprom_enable_strap(eeprom_enable_strap),
  .eeprom_serial_line_in(eeprom_serial_line_in),
  .overcurrent_n(overcurrent_n),
  .upstream_pullup_ctrl_out(upstream_pullup_ctrl_out),
  .upstream_pullup_ctrl_oe(upstream_pullup_ctrl_oe),
  .eeprom_serial_clock_oe(eeprom_serial_clock_oe),
  .eeprom_serial_clock_pd_en(eeprom_serial_clock_pd_en),
  .eeprom_serial_line_pd_en(eeprom_serial_line_pd_en),
  .port_power_on_n(port_power_on_n),
  .self_powered(self_powered),
  .ganged_mode(ganged_mode),
  .vendor_id(vendor_id),
  .product_id(product_id)
);
`default_nettype wire

// file: dv/hub_strap_and_pullup_control_tb_top.sv
// Self-checking bench for the strap and pullup control block
`timescale 1ns/1ns
`default_nettype none
`include "hub_strap_map.svh"

module hub_strap_and_pullup_control_tb_top;
  import hub_strap_pkg::*;
  localparam int D = 20;
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  word_type pwdata, prdata, rd;
  logic self_sel, off_sel, gang_sel, usb_rst, psrc, ext, ln_in;
  port_vec_type fault_n, oc_n, pwr_n;
  logic pu_out, pu_oe, ck_out, ck_oe, ck_pd, ln_out, ln_oe, ln_pd;
  logic self_p, gang_m;
  logic [15:0] vid, pid;
  int error_cnt, samples_checked;

  hub_strap_and_pullup_control #(
    .PULLUP_DELAY_CYCLES(`DELAY_COUNT_WIDTH'(D))
  ) u_hub_strap_and_pullup_control (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_source_strap(psrc), .eeprom_enable_strap(ext),
    .usb_bus_reset(usb_rst), .upstream_pullup_ctrl_out(pu_out),
    .upstream_pullup_ctrl_oe(pu_oe), .eeprom_serial_clock_out(ck_out),
    .eeprom_serial_clock_oe(ck_oe), .eeprom_serial_clock_pd_en(ck_pd),
    .eeprom_serial_line_in(ln_in), .eeprom_serial_line_out(ln_out),
    .eeprom_serial_line_oe(ln_oe), .eeprom_serial_line_pd_en(ln_pd),
    .overcurrent_n(oc_n), .port_power_on_n(pwr_n),
    .self_powered(self_p), .ganged_mode(gang_m),
    .vendor_id(vid), .product_id(pid));

  hub_board_model u_hub_board_model (
    .self_power_sel(self_sel), .eeprom_off_sel(off_sel),
    .gang_sel(gang_sel), .fault_n(fault_n), .line_out(ln_out),
    .line_oe(ln_oe), .line_pd_en(ln_pd), .power_source_strap(psrc),
    .eeprom_enable_strap(ext), .eeprom_serial_line_in(ln_in),
    .overcurrent_n(oc_n));

  // Free-running core clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // Wait n edges, then step past them so their updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One APB transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [11:0] a, input word_type d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      $display("unexpected at %0t: bus hang", $time);
      end_of_test();
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input word_type m, exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp, "read data");
  endtask

  // Main sequence
  initial begin
    {reset_n, psel, penable, pwrite, usb_rst, self_sel, gang_sel} = 7'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    off_sel = 1'b1;
    fault_n = 3'h7;
    error_cnt = 0;
    samples_checked = 0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(D);
    chk(pu_oe, 1'b0, "pullup early");
    cyc(1);
    chk({pu_oe, pu_out}, 2'h3, "pullup late");
    chk({vid, pid}, {`DEFAULT_VENDOR_ID, `DEFAULT_PRODUCT_ID}, "ids");
    rd_chk(`ADDR_STATUS, 32'h0003_000F, 32'h0000_0008);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("reset test done");
    @(posedge ref_clk);
    self_sel <= 1'b1;
    cyc(2);
    chk(pu_oe, 1'b1, "pullup dropped early");
    cyc(1);
    chk({pu_oe, self_p}, 2'h1, "strap change");
    repeat (5) @(posedge ref_clk);
    self_sel <= 1'b0;
    cyc(D + 3);
    chk(pu_oe, 1'b0, "no restart");
    cyc(1);
    chk({pu_oe, self_p}, 2'h2, "restart delay");
    $display("strap test done");
    apb(1'b1, `ADDR_CTRL, 32'h0000_0700);
    cyc(2);
    chk(pwr_n, 3'h0, "ports off");
    @(posedge ref_clk);
    fault_n <= 3'h5;
    cyc(5);
    chk(pwr_n, 3'h2, "per-port trip");
    @(posedge ref_clk);
    fault_n <= 3'h7;
    usb_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    usb_rst <= 1'b0;
    cyc(2);
    chk({pu_oe, pwr_n}, 4'h8, "bus reset");
    @(posedge ref_clk);
    gang_sel <= 1'b1;
    cyc(6);
    chk(gang_m, 1'b1, "ganged select");
    @(posedge ref_clk);
    fault_n <= 3'h6;
    cyc(5);
    chk(pwr_n, 3'h7, "ganged trip");
    @(posedge ref_clk);
    fault_n <= 3'h7;
    cyc(4);
    apb(1'b1, `ADDR_OC_CLEAR, 32'h0000_0007);
    cyc(2);
    chk(pwr_n, 3'h0, "fault clear");
    $display("power test done");
    @(posedge ref_clk);
    gang_sel <= 1'b0;
    off_sel <= 1'b0;
    cyc(6);
    apb(1'b1, `ADDR_ID_LOAD, 32'h9ABC_DEF0);
    apb(1'b1, `ADDR_CTRL, 32'h0000_001F);
    cyc(2);
    chk({ck_out, ck_oe, ck_pd, ln_out, ln_oe, ln_pd}, 6'h3F, "pins");
    chk({vid, pid}, {16'hDEF0, 16'h9ABC}, "loaded ids");
    rd_chk(`ADDR_ID, 32'hFFFF_FFFF, 32'h9ABC_DEF0);
    rd_chk(`ADDR_STATUS, 32'h0000_0016, 32'h0000_0012);
    apb(1'b1, `ADDR_CTRL, 32'h0000_000B);
    cyc(2);
    rd_chk(`ADDR_STATUS, 32'h0000_0010, 32'h0000_0000);
    @(posedge ref_clk);
    off_sel <= 1'b1;
    cyc(6);
    apb(1'b1, `ADDR_CTRL, 32'h0000_001F);
    cyc(2);
    chk({ck_oe, ck_pd, ln_oe, ln_pd, gang_m}, 5'h0, "disabled");
    chk({vid, pid}, {`DEFAULT_VENDOR_ID, `DEFAULT_PRODUCT_ID},
      "ids kept");
    $display("eeprom test done");
    end_of_test();
  end
endmodule
`default_nettype wire
